// ==== dcps_ddr2_cmd_power.v ====
// Purpose: ddr2 command decode, open-row tracking and cke power states
// Assumes: one clock, async active-low reset, pins sampled through two flops
// Notes: burst datapath left out; only burst busy and write mask kept
`include "dcps_consts.vh"
module dcps_ddr2_cmd_power (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_x16,
    input wire i_cke,
    input wire i_cs_n,
    input wire i_ras_n,
    input wire i_cas_n,
    input wire i_we_n,
    input wire [1:0] i_ba,
    input wire [12:0] i_addr,
    input wire i_odt,
    input wire [1:0] i_dm,
    output reg [4:0] o_state,
    output reg [3:0] o_cmd,
    output reg o_cmd_valid,
    output reg [1:0] o_bank,
    output reg [12:0] o_row,
    output reg [9:0] o_col,
    output reg o_auto_pre,
    output reg o_mrs_valid,
    output reg [1:0] o_mrs_sel,
    output reg [12:0] o_mrs_op,
    output reg [3:0] o_bank_open,
    output reg o_burst_busy,
    output reg [1:0] o_byte_we,
    output reg o_dll_on,
    output reg o_odt_on,
    output reg o_rd_allowed
);
    // two-flop synchronisers for cke, command, bank, address, odt and mask pins
    reg [25:0] sync1;
    reg [25:0] sync2;
    wire cke;
    wire cs_n;
    wire ras_n;
    wire cas_n;
    wire we_n;
    wire [1:0] ba;
    wire [12:0] addr;
    wire odt;
    wire [1:0] dm;
    reg cke_prev;
    reg [4:0] state;
    reg [4:0] next_state;
    reg [2:0] burst_cnt;
    reg [7:0] xsrd_cnt;
    wire [3:0] cmd;
    wire sel;
    wire exec;

    // one decoded command that executes at this edge
    function cmd_hit;
        input exec_now;
        input [3:0] code_now;
        input [3:0] code_want;
        begin
            cmd_hit = exec_now & (code_now == code_want);
        end
    endfunction

    // async exit path: cke high releases self refresh without the clock
    wire sref_exit_n = i_rst_n & ~(state[4] & i_cke); // RULE6

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= 26'h0;
            sync2 <= 26'h0;
        end else if (i_ce) begin
            sync1 <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba,
                      i_addr, i_odt, i_dm, 3'h0};
            sync2 <= sync1;
        end
    end

    assign {cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm} =
        sync2[25:3];
    // all four strobes sampled together into one command code
    assign cmd = {cs_n, ras_n, cas_n, we_n}; // RULE1
    // deselect and nop never count as executed commands
    assign sel = ~cs_n & (cmd != `DCPS_CMD_NOP); // RULE17 RULE18
    assign exec = sel & cke_prev & cke;
    // decoded strobes; commands with cke low never reach these
    wire hit_act = cmd_hit(exec, cmd, `DCPS_CMD_ACT);
    wire hit_pre = cmd_hit(exec, cmd, `DCPS_CMD_PRE);
    wire hit_mrs = cmd_hit(exec, cmd, `DCPS_CMD_MRS);
    wire hit_rw = cmd_hit(exec, cmd, `DCPS_CMD_RD) |
                  cmd_hit(exec, cmd, `DCPS_CMD_WR);

    // state transitions from registered cke levels and commands only
    always @* begin
        next_state = state; // RULE24
        case (state)
            `DCPS_ST_IDLE, `DCPS_ST_ACT: begin
                if (cke_prev && !cke) begin
                    if (sel && cmd == `DCPS_CMD_REF)
                        next_state = `DCPS_ST_SREF; // RULE10
                    else if (o_bank_open != 4'h0)
                        next_state = `DCPS_ST_APD; // RULE8 RULE9
                    else
                        next_state = `DCPS_ST_PPD; // RULE9
                end else if (exec && cmd == `DCPS_CMD_ACT)
                    next_state = `DCPS_ST_ACT;
                else if (o_bank_open == 4'h0)
                    next_state = `DCPS_ST_IDLE;
                else
                    next_state = `DCPS_ST_ACT;
            end
            // low cke holds power-down, high cke exits it
            `DCPS_ST_APD: if (cke) next_state = `DCPS_ST_ACT; // RULE8
            `DCPS_ST_PPD: if (cke) next_state = `DCPS_ST_IDLE; // RULE8
            `DCPS_ST_SREF: next_state = `DCPS_ST_SREF;
            default: next_state = `DCPS_ST_IDLE;
        endcase
    end

    // state register, also released from self refresh asynchronously
    always @(posedge i_core_clk or negedge sref_exit_n) begin
        if (!sref_exit_n) begin
            state <= `DCPS_ST_IDLE; // RULE6
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // last cke sample and executed command capture
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cke_prev <= 1'b0;
            o_cmd <= `DCPS_CMD_NOP;
            o_cmd_valid <= 1'b0;
            o_bank <= 2'h0;
        end else if (i_ce) begin
            cke_prev <= cke;
            o_cmd_valid <= exec;
            if (exec) begin
                o_cmd <= cmd; // RULE1
                o_bank <= ba; // RULE2
            end
        end
    end

    // mode set pulse; bank inputs pick the mode register
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mrs_valid <= 1'b0;
            o_mrs_sel <= 2'h0;
            o_mrs_op <= 13'h0;
        end else if (i_ce) begin
            o_mrs_valid <= hit_mrs;
            if (hit_mrs) begin
                o_mrs_sel <= ba; // RULE2
                o_mrs_op <= addr;
            end
        end
    end

    // open-row flags; all-bank precharge bit closes every bank at once
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bank_open <= 4'h0;
            o_row <= 13'h0;
        end else if (i_ce) begin
            if (hit_act) begin
                o_bank_open[ba] <= 1'b1; // RULE20
                o_row <= addr;
            end else if (hit_pre) begin
                if (addr[`DCPS_PRE_ALL_BIT])
                    o_bank_open <= 4'h0; // RULE20
                else
                    o_bank_open[ba] <= 1'b0; // RULE20
            end
        end
    end

    // column capture and burst count; a new access only reloads it
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_col <= 10'h0;
            o_auto_pre <= 1'b0;
            burst_cnt <= 3'h0;
        end else if (i_ce) begin
            if (hit_rw) begin
                // a9 masked off for sixteen-bit columns
                o_col <= {addr[9] & ~i_x16, addr[8:0]}; // RULE7
                o_auto_pre <= addr[`DCPS_PRE_ALL_BIT];
                burst_cnt <= `DCPS_BURST_LEN; // RULE3
            end else if (burst_cnt != 3'h0) begin
                // no command cuts the burst short
                burst_cnt <= burst_cnt - 3'h1; // RULE3
            end
        end
    end

    // byte enable is the inverse of the sampled mask, writes only
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_byte_we <= 2'h0;
        end else if (i_ce) begin
            o_byte_we <= (o_cmd == `DCPS_CMD_WR && burst_cnt != 3'h0) ?
                         ~dm : 2'h0; // RULE16
        end
    end

    // read-ready count; held at zero for as long as self refresh lasts
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xsrd_cnt <= 8'h0;
        end else if (i_ce) begin
            if (state[4])
                xsrd_cnt <= 8'h0;
            else if (xsrd_cnt != `DCPS_XSRD_CLKS)
                xsrd_cnt <= xsrd_cnt + 8'h1;
        end
    end

    // status outputs; termination gated off in self refresh only
    always @* begin
        o_state = state;
        o_burst_busy = (burst_cnt != 3'h0);
        o_dll_on = ~state[4]; // RULE23
        o_odt_on = odt & ~state[4]; // RULE5
        o_rd_allowed = (xsrd_cnt == `DCPS_XSRD_CLKS);
    end
endmodule

// ==== dcps_consts.vh ====
// Purpose: constants for the ddr2 command decode and power-state block
// Assumes: included once per design file, plain verilog-2005
// Notes: command codes are {cs_n, ras_n, cas_n, we_n}
// Function
// (RULE1) decode command from cs, ras, cas, we, cke on each rising edge
// (RULE2) bank address picks target bank, or mode register for mode set
// (RULE3) length-four read or write bursts run to completion, never truncated
// (RULE4) controller bounds power-down time; device does no refresh then
// (RULE5) termination input ignored in self refresh; never affects decode
// (RULE6) self refresh exit is asynchronous on cke returning high
// (RULE7) sixteen-bit mode: a9 don't-care for read and write columns
// (RULE8) cke fall enters power-down, rise exits; only nop or deselect
// (RULE9) open row at entry gives active power-down, else precharge
// (RULE10) refresh with cke falling enters self refresh, banks idle
// (RULE11) after self refresh exit, only nop/deselect; reads after 200 clocks
// (RULE12) controller never enters low power during pending operations
// (RULE13) controller holds cke for three registered edges after change
// (RULE14) controller keeps cke high during driver calibration
// (RULE15) controller drives termination defined in power-down when enabled
// (RULE16) write byte stored when mask low, discarded when mask high
// (RULE17) deselect accepts no new command; ongoing work continues
// (RULE18) nop registers no command; ongoing work continues
// (RULE19) mode set only with all banks idle, then wait mode delay
// (RULE20) activate opens row until precharge; precharge before new row
// (RULE21) controller never issues unlisted state, cke, command mixes
// (RULE22) refresh needs idle banks; address ignored during refresh
// (RULE23) delay-locked loop off in self refresh, on after exit
// (RULE24) power-state tracker driven only by registered cke and commands; self refresh exit also uses raw i_cke asynchronously
`ifndef DCPS_CONSTS_VH
`define DCPS_CONSTS_VH
`define DCPS_CMD_MRS 4'h0
`define DCPS_CMD_REF 4'h1
`define DCPS_CMD_PRE 4'h2
`define DCPS_CMD_ACT 4'h3
`define DCPS_CMD_WR 4'h4
`define DCPS_CMD_RD 4'h5
`define DCPS_CMD_NOP 4'h7
`define DCPS_BURST_LEN 3'h4
`define DCPS_XSRD_CLKS 8'hc8
`define DCPS_PRE_ALL_BIT 10
`define DCPS_ST_IDLE 5'h01
`define DCPS_ST_ACT 5'h02
`define DCPS_ST_APD 5'h04
`define DCPS_ST_PPD 5'h08
`define DCPS_ST_SREF 5'h10
`endif

// ==== dcps_cmd_power_props.sv ====
// Purpose: pin-to-output timing of decode and power states
// Assumes: i_ce held high, pins move at falling edges
// Notes: attached to every design instance by bind
module dcps_cmd_power_props (
    input wire i_core_clk, i_rst_n, i_x16, i_cke,
    input wire i_cs_n, i_ras_n, i_cas_n, i_we_n,
    input wire [1:0] i_ba, o_bank, o_mrs_sel,
    input wire [12:0] i_addr,
    input wire [4:0] o_state,
    input wire [3:0] o_cmd, o_bank_open,
    input wire [9:0] o_col,
    input wire o_cmd_valid, o_mrs_valid, o_burst_busy, o_dll_on, o_odt_on
);
    // command on the pins; two sync flops put answers 3 edges on
    wire [3:0] pc = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    act_lat_a: assert property (
        i_cke && $past(i_cke) && pc == 4'h3 |-> ##3 o_cmd_valid &&
        o_cmd == 4'h3 && o_bank == $past(i_ba, 3)) else $error("act lost");
    nop_quiet_a: assert property (
        i_cs_n || pc == 4'h7 |-> ##3 !o_cmd_valid) else $error("idle ran");
    col_mask_a: assert property (
        i_cke && $past(i_cke) && (pc == 4'h4 || pc == 4'h5) |-> ##3
        o_col == {$past(i_addr[9], 3) & ~i_x16, $past(i_addr[8:0], 3)})
        else $error("column wrong");
    mrs_sel_a: assert property (
        i_cke && $past(i_cke) && pc == 4'h0 |-> ##3 o_mrs_valid &&
        o_mrs_sel == $past(i_ba, 3)) else $error("mode select wrong");
    burst_len_a: assert property (
        $rose(o_burst_busy) |-> o_burst_busy [*4]) else $error("burst cut");
    sref_off_a: assert property (
        o_state == 5'h10 |-> !o_dll_on && !o_odt_on) else $error("sref on");
    sref_async_a: assert property (
        o_state == 5'h10 |-> !i_cke) else $error("sref kept");
    pd_kind_a: assert property (
        o_state == 5'h04 || o_state == 5'h08 |->
        (o_bank_open != 4'h0) == (o_state == 5'h04)) else $error("pd kind");
endmodule
bind dcps_ddr2_cmd_power dcps_cmd_power_props u_props (.i_core_clk,
    .i_rst_n, .i_x16, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n, .i_ba,
    .o_bank, .o_mrs_sel, .i_addr, .o_state, .o_cmd, .o_bank_open, .o_col,
    .o_cmd_valid, .o_mrs_valid, .o_burst_busy, .o_dll_on, .o_odt_on);

// ==== dcps_ctrl_model.sv ====
// Purpose: memory controller model driving the command pins
// Assumes: pins change on falling edges only
// Notes: termination held at a defined level throughout
module dcps_ctrl_model (
    input wire logic i_core_clk,
    output logic o_cke = 1'b1,
    output logic [3:0] o_cmd = 4'h7,
    output logic [1:0] o_ba = 2'h0,
    output logic [12:0] o_addr = 13'h0000,
    output logic o_odt = 1'b1,
    output logic [1:0] o_dm = 2'h0
);
    // one command for one edge; address left is inverted, not held
    task automatic issue(input logic [3:0] c, input logic [1:0] b,
        input logic [12:0] a, input logic [1:0] m);
        @(negedge i_core_clk);
        o_cmd <= c;
        o_ba <= b;
        o_addr <= a;
        o_dm <= m;
        @(negedge i_core_clk);
        o_cmd <= 4'h7;
        o_ba <= ~b;
        o_addr <= ~a;
    endtask
    // new cke level kept for three registered edges
    task automatic set_cke(input logic v, input logic [3:0] c);
        @(negedge i_core_clk);
        o_cke <= v;
        o_cmd <= c;
        @(negedge i_core_clk);
        o_cmd <= 4'h7;
        repeat (2) @(negedge i_core_clk);
    endtask
endmodule

// ==== dcps_ddr2_cmd_power_tb.sv ====
// Purpose: self-checking bench for decode and power states
// Assumes: sixteen-bit configuration, clock enable held high
// Notes: all pin traffic goes through the controller model
module dcps_ddr2_cmd_power_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cke, odt, o_cmd_valid, o_auto_pre, o_mrs_valid, o_burst_busy;
    logic o_dll_on, o_odt_on, o_rd_allowed;
    logic [3:0] cmd, o_cmd, o_bank_open;
    logic [1:0] ba, dm, o_bank, o_mrs_sel, o_byte_we;
    logic [12:0] addr, o_row, o_mrs_op;
    logic [9:0] o_col;
    logic [4:0] o_state;
    int errors = 0;
    int checks_done = 0;
    always #2 i_core_clk = ~i_core_clk;
    dcps_ctrl_model u_dcps_ctrl_model (.i_core_clk, .o_cke(cke),
        .o_cmd(cmd), .o_ba(ba), .o_addr(addr), .o_odt(odt), .o_dm(dm));
    dcps_ddr2_cmd_power u_dcps_ddr2_cmd_power (.i_core_clk, .i_rst_n,
        .i_ce(1'b1), .i_x16(1'b1), .i_cke(cke), .i_cs_n(cmd[3]),
        .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba),
        .i_addr(addr), .i_odt(odt), .i_dm(dm), .o_state, .o_cmd,
        .o_cmd_valid, .o_bank, .o_row, .o_col, .o_auto_pre, .o_mrs_valid,
        .o_mrs_sel, .o_mrs_op, .o_bank_open, .o_burst_busy, .o_byte_we,
        .o_dll_on, .o_odt_on, .o_rd_allowed);
    task automatic wt(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // activate, then a write with a9 set and the low byte masked
    task automatic t_act_wr;
        u_dcps_ctrl_model.issue(4'h3, 2'h2, 13'h1abc, 2'h0);
        wt(2);
        chk(o_cmd_valid, 1'b1);
        chk(o_row, 13'h1abc);
        wt(1);
        chk(o_state, 5'h02);
        u_dcps_ctrl_model.issue(4'h4, 2'h2, 13'h0212, 2'h1);
        wt(3);
        chk(o_col, 10'h012);
        wt(1);
        chk(o_byte_we, 2'h2);
        u_dcps_ctrl_model.issue(4'hb, 2'h1, 13'h0400, 2'h0);
        wt(3);
        chk(o_cmd_valid, 1'b0);
        chk({o_bank_open, o_cmd, o_burst_busy}, 9'h088);
        // read with auto precharge; wait out the burst before low power
        u_dcps_ctrl_model.issue(4'h5, 2'h2, 13'h0400, 2'h1);
        wt(6);
        chk({o_auto_pre, o_bank, o_odt_on}, 4'hd);
    endtask
    // active then precharge power-down, with a mode set between
    task automatic t_pd;
        u_dcps_ctrl_model.set_cke(1'b0, 4'h7);
        wt(3);
        chk(o_state, 5'h04);
        u_dcps_ctrl_model.set_cke(1'b1, 4'h7);
        u_dcps_ctrl_model.issue(4'h2, 2'h0, 13'h0400, 2'h0);
        wt(4);
        chk({o_bank_open, o_state}, 9'h001);
        u_dcps_ctrl_model.issue(4'h0, 2'h1, 13'h0042, 2'h0);
        wt(2);
        chk({o_mrs_valid, o_mrs_sel, o_mrs_op}, 16'ha042);
        u_dcps_ctrl_model.set_cke(1'b0, 4'h7);
        wt(3);
        chk(o_state, 5'h08);
        u_dcps_ctrl_model.set_cke(1'b1, 4'h7);
        wt(3);
        chk(o_state, 5'h01);
    endtask
    // self refresh, asynchronous exit, then the read hold-off count
    task automatic t_sref;
        u_dcps_ctrl_model.set_cke(1'b0, 4'h1);
        wt(3);
        chk({o_state, o_dll_on, o_odt_on}, 7'h40);
        fork
            u_dcps_ctrl_model.set_cke(1'b1, 4'h7);
            begin
                @(posedge cke);
                #1;
                chk(o_state, 5'h01);
            end
        join
        chk({o_dll_on, o_rd_allowed}, 2'h2);
        wt(190);
        chk(o_rd_allowed, 1'b0);
        wt(15);
        chk(o_rd_allowed, 1'b1);
    endtask
    initial begin
        wt(5);
        i_rst_n <= 1'b1;
        wt(1);
        chk({o_state, o_cmd, o_dll_on}, 10'h02f);
        t_act_wr();
        t_pd();
        t_sref();
        complete_run();
    end
    // a hang costs far more than the planned run of some 1.1 us
    initial begin
        #20000;
        errors++;
        complete_run();
    end
endmodule
